//--- bench/cfg_host_model.sv
// Host and chained-device model on the open-drain init and done lines.
// Assumes pull-ups on both lines and a bench-driven program command.
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
	input  wire logic init_oe_n_in,
	input  wire logic done_oe_n_in,
	input  wire logic hold_init_in,
	input  wire logic hold_done_in,
	input  wire logic run_in,
	input  wire logic prog_in,
	output logic      init_wire_out,
	output logic      done_wire_out,
	output logic      clk_out,
	output logic      prog_n_out
);
	// ****************
	// Lines and clock
	// ****************
	// A pulled-up line is high only when no party drives it low.
	assign init_wire_out = init_oe_n_in & ~hold_init_in;
	assign done_wire_out = done_oe_n_in & ~hold_done_in;
	assign prog_n_out = prog_in;
	// The start-up clock stands still while run_in is low.
	initial clk_out = 1'b0;
	always #62.5 clk_out = run_in ? ~clk_out : 1'b0;
endmodule
`default_nettype wire

//--- bench/config_startup_sequencer_assertions.sv
// Port checker for the configuration sequencer.
// Assumes it is bound to the sequencer top module.
`timescale 1ns/1ps
`default_nettype none
module cfg_seq_checker
	import cfg_seq_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_in,
	input wire logic        program_request_n_in,
	input wire logic [2:0]  mode_select_in,
	input wire logic        readback_request_in,
	input wire logic        capture_request_in,
	input wire logic [31:0] chain_bit_count_in,
	input wire logic        init_status_n_oe_n_out,
	input wire logic        config_done_oe_n_out,
	input wire logic        global_set_reset_out,
	input wire logic        global_output_tristate_out,
	input wire logic        global_write_enable_sig_out,
	input wire logic        readback_enable_out,
	input wire logic        capture_strobe_out,
	input wire logic        chain_length_error_out,
	input wire logic        configured_out
);
	// ****************
	// Properties
	// ****************
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	property p_clear; $fell(rst_in) |-> !init_status_n_oe_n_out [*3]; endproperty
	a_clear: assert property (p_clear) else $error("clearing too short");
	property p_gsr; !init_status_n_oe_n_out |-> global_set_reset_out; endproperty
	a_gsr: assert property (p_gsr) else $error("set/reset low in clearing");
	property p_we; $rose(global_write_enable_sig_out) |-> !$past(global_output_tristate_out);
		endproperty
	a_we: assert property (p_we) else $error("write enable before tristate");
	property p_lag; $fell(global_output_tristate_out) && !$past(global_write_enable_sig_out)
		|-> !global_write_enable_sig_out [*4]; endproperty
	a_lag: assert property (p_lag) else $error("write enable not lagging");
	property p_done; $rose(configured_out) |-> config_done_oe_n_out; endproperty
	a_done: assert property (p_done) else $error("done held at end");
	property p_rb; readback_enable_out |-> readback_request_in
		&& (mode_select_in == mode_slave_par || mode_select_in == mode_test); endproperty
	a_rb: assert property (p_rb) else $error("readback in wrong mode");
	property p_cap; capture_strobe_out |-> $past(capture_request_in); endproperty
	a_cap: assert property (p_cap) else $error("capture without request");
	property p_chain; chain_length_error_out |-> $past(chain_bit_count_in) > max_chain_bits
		&& $past(mode_select_in) == mode_slave_serial; endproperty
	a_chain: assert property (p_chain) else $error("false chain error");
	property p_abort; $fell(program_request_n_in) |-> ##[1:8] (!config_done_oe_n_out
		&& global_output_tristate_out && !global_write_enable_sig_out); endproperty
	a_abort: assert property (p_abort) else $error("program did not abort");
endmodule
bind config_startup_sequencer cfg_seq_checker chk (
	.clk_in                      (clk_in),
	.rst_in                      (rst_in),
	.program_request_n_in        (program_request_n_in),
	.mode_select_in              (mode_select_in),
	.readback_request_in         (readback_request_in),
	.capture_request_in          (capture_request_in),
	.chain_bit_count_in          (chain_bit_count_in),
	.init_status_n_oe_n_out      (init_status_n_oe_n_out),
	.config_done_oe_n_out        (config_done_oe_n_out),
	.global_set_reset_out        (global_set_reset_out),
	.global_output_tristate_out  (global_output_tristate_out),
	.global_write_enable_sig_out (global_write_enable_sig_out),
	.readback_enable_out         (readback_enable_out),
	.capture_strobe_out          (capture_strobe_out),
	.chain_length_error_out      (chain_length_error_out),
	.configured_out              (configured_out)
);
`default_nettype wire

//--- bench/config_startup_sequencer_tb.sv
// Self-checking bench for the configuration start-up sequencer.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer_tb;
	import cfg_seq_pkg::*;
	// ****************
	// Signals
	// ****************
	logic clk_in = 1'b0, rst_in = 1'b1, prog = 1'b1, hold_init = 1'b0, hold_done = 1'b0;
	logic run = 1'b0, load_complete_in = 1'b0, crc_error_in = 1'b0, capture_request_in = 1'b0;
	logic readback_request_in = 1'b0, fabric_set_reset_in = 1'b0, fabric_tristate_in = 1'b0;
	logic [1:0] startup_clock_select_in = 2'h0, oscillator_rate_select_in = 2'h1;
	logic [2:0] mode_select_in = 3'h6, done_phase_in = 3'h4, tristate_release_phase_in = 3'h5;
	logic [2:0] write_enable_phase_in = 3'h6, lock_wait_phase_in = 3'h7, d, t, w;
	logic [3:0] lock_wait_mask_in = 4'h0, clock_manager_locked_in = 4'h0;
	logic [31:0] chain_bit_count_in = 32'h0;
	wire logic program_request_n_in, init_status_n_in, config_done_in, lclk, init_status_n_out;
	wire logic init_status_n_oe_n_out, config_done_out, config_done_oe_n_out, capture_strobe_out;
	wire logic global_set_reset_out, global_output_tristate_out, global_write_enable_sig_out;
	wire logic readback_enable_out, chain_length_error_out, configured_out;
	wire logic [1:0] oscillator_rate_select_out;
	wire logic [2:0] startup_phase_out;
	int num_errors = 0, comparisons = 0, cycles = 0, p_done = -1, p_gts = -1, p_gwe = -1;
	wire logic config_clock_in = lclk & (startup_clock_select_in == clk_sel_config);
	wire logic fabric_clock_source_in = lclk & (startup_clock_select_in == clk_sel_fabric);
	wire logic tck_in = lclk & (startup_clock_select_in == clk_sel_test);
	cfg_host_model host (.init_oe_n_in(init_status_n_oe_n_out), .done_oe_n_in(config_done_oe_n_out),
		.hold_init_in(hold_init), .hold_done_in(hold_done), .run_in(run), .prog_in(prog),
		.init_wire_out(init_status_n_in), .done_wire_out(config_done_in), .clk_out(lclk),
		.prog_n_out(program_request_n_in));
	config_startup_sequencer #(.CLEAR_CYCLES(4)) dut (.*);
	// ****************
	// Clock, monitor and tasks
	// ****************
	always #2 clk_in = ~clk_in;
	always @(negedge clk_in) begin
		cycles++;
		if (config_done_oe_n_out && p_done < 0) p_done = startup_phase_out;
		if (!global_output_tristate_out && p_gts < 0) p_gts = startup_phase_out;
		if (global_write_enable_sig_out && p_gwe < 0) p_gwe = startup_phase_out;
		if (cycles == 60000) begin
			num_errors++;
			results();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	task automatic configure(input logic [2:0] dp, input logic [2:0] tp, input logic [2:0] wp);
		{done_phase_in, tristate_release_phase_in, write_enable_phase_in} = {dp, tp, wp};
		run = 1'b0;
		load_complete_in = 1'b0;
		prog = 1'b0;
		tick(80);
		chk("abort gts", global_output_tristate_out, 1);
		chk("abort gwe", global_write_enable_sig_out, 0);
		chk("abort done", config_done_oe_n_out, 0);
		chk("init level", init_status_n_out, 0);
		chk("done level", config_done_out, 0);
		{p_done, p_gts, p_gwe} = {-32'sd1, -32'sd1, -32'sd1};
		prog = 1'b1;
		for (int i = 0; i < 3000 && !init_status_n_in; i++) tick(1);
		chk("init", init_status_n_in, 1);
		chk("start rate", oscillator_rate_select_out, rate_3mhz);
		load_complete_in = 1'b1;
		run = 1'b1;
		for (int i = 0; i < 4000 && !configured_out; i++) tick(1);
		chk("configured", configured_out, 1);
	endtask
	task automatic results;
		$display("comparisons %0d, mismatches %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// ****************
	// Tests
	// ****************
	initial begin
		void'($urandom(63751));
		tick(20);
		chk("reset rate", oscillator_rate_select_out, rate_3mhz);
		chk("reset gsr", global_set_reset_out, 1);
		rst_in = 1'b0;
		for (int k = 0; k < 3; k++) begin
			startup_clock_select_in = 2'(k);
			oscillator_rate_select_in = 2'($urandom);
			d = k ? 3'($urandom_range(1, 4)) : 3'h4;
			t = d + 3'h1;
			w = k ? 3'($urandom_range(t + 1, 6)) : 3'h6;
			configure(d, t, w);
			chk("gts lag", p_gts - p_done, t - d);
			chk("gwe lag", p_gwe - p_gts, w - t);
			chk("gsr end", global_set_reset_out, 0);
			chk("rate", oscillator_rate_select_out, oscillator_rate_select_in);
			$display("test clock source %0d done", k);
		end
		run = 1'b0;
		load_complete_in = 1'b0;
		prog = 1'b0;
		tick(80);
		prog = 1'b1;
		for (int i = 0; i < 3000 && !init_status_n_in; i++) tick(1);
		crc_error_in = 1'b1;
		tick(10);
		chk("crc init", init_status_n_in, 0);
		load_complete_in = 1'b1;
		run = 1'b1;
		tick(400);
		chk("crc hold", configured_out, 0);
		crc_error_in = 1'b0;
		$display("test crc done");
		hold_init = 1'b1;
		fork
			configure(3'h4, 3'h5, 3'h6);
			begin
				tick(100);
				load_complete_in = 1'b1;
				run = 1'b1;
				tick(400);
				chk("held phase", startup_phase_out, 0);
				hold_init = 1'b0;
			end
		join
		lock_wait_phase_in = 3'h2;
		lock_wait_mask_in = 4'h5;
		clock_manager_locked_in = 4'h1;
		fork
			configure(3'h4, 3'h5, 3'h6);
			begin
				tick(2500);
				chk("lock stall", configured_out, 0);
				chk("lock gts", global_output_tristate_out, 1);
				clock_manager_locked_in = 4'h5;
			end
		join
		lock_wait_phase_in = phase_no_wait;
		hold_done = 1'b1;
		fork
			configure(3'h4, phase_done_wait, phase_done_wait);
			begin
				tick(1500);
				chk("chain gts", global_output_tristate_out, 1);
				hold_done = 1'b0;
			end
		join
		tick(300);
		chk("chain gwe", global_write_enable_sig_out, 1);
		$display("test waits done");
		{fabric_tristate_in, fabric_set_reset_in, capture_request_in} = 3'h7;
		tick(8);
		chk("fabric gts", global_output_tristate_out, 1);
		chk("fabric gsr", global_set_reset_out, 1);
		chk("capture", capture_strobe_out, 1);
		{fabric_tristate_in, fabric_set_reset_in, capture_request_in} = 3'h0;
		readback_request_in = 1'b1;
		for (int m = 0; m < 8; m++) begin
			mode_select_in = 3'(m);
			chain_bit_count_in = max_chain_bits + (m[0] ? 32'($urandom_range(1, 31)) : 32'h0);
			tick(3);
			chk("readback", readback_enable_out, m == mode_test || m == mode_slave_par);
			chk("chain limit", chain_length_error_out, m == mode_slave_serial);
		end
		mode_select_in = mode_slave_serial;
		chain_bit_count_in = max_chain_bits;
		tick(3);
		chk("chain edge", chain_length_error_out, 0);
		$display("test user state done");
		results();
	end
endmodule
`default_nettype wire

//--- hw/cfg_seq_pkg.sv
// Constants and types shared by the configuration start-up sequencer.
// Assumes a single 250 MHz system clock and synchronous active-high reset.
package cfg_seq_pkg;
	localparam logic [2:0] phase_done_wait    = 3'h7;
	localparam logic [2:0] phase_no_wait      = 3'h7;
	localparam logic [2:0] done_phase_default = 3'h4;
	localparam logic [2:0] tri_phase_default  = 3'h5;
	localparam logic [2:0] we_phase_default   = 3'h6;
	localparam logic [2:0] last_phase         = 3'h7;
	localparam logic [1:0] clk_sel_config     = 2'h0;
	localparam logic [1:0] clk_sel_fabric     = 2'h1;
	localparam logic [1:0] clk_sel_test       = 2'h2;
	localparam logic [1:0] rate_3mhz          = 2'h0;
	localparam logic [1:0] rate_6mhz          = 2'h1;
	localparam logic [1:0] rate_12mhz         = 2'h2;
	localparam logic [1:0] rate_25mhz         = 2'h3;
	localparam logic [2:0] mode_slave_par     = 3'h6;
	localparam logic [2:0] mode_test          = 3'h5;
	localparam logic [2:0] mode_slave_serial  = 3'h7;
	localparam logic [31:0] max_chain_bits    = 32'hffffffe0;
	localparam int          clk_mhz           = 250;
	localparam int          clear_cycles      = 16;
	typedef enum logic [2:0] {st_clear, st_init_wait, st_load, st_startup, st_user}
		cfg_state_t;
endpackage

//--- hw/config_startup_sequencer.sv
// Configuration sequencer: clearing, loading and programmable start-up.
// Assumes external pull-ups on the open-drain init and done lines, and
// that the pins and alternative clocks are asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module config_startup_sequencer
	import cfg_seq_pkg::*;
#(
	parameter int CLEAR_CYCLES = clear_cycles,
	parameter int LOCK_WIDTH   = 4
) (
	input  wire logic                  clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  program_request_n_in,
	input  wire logic                  init_status_n_in,
	output logic                       init_status_n_out,
	output logic                       init_status_n_oe_n_out,
	input  wire logic                  config_done_in,
	output logic                       config_done_out,
	output logic                       config_done_oe_n_out,
	input  wire logic                  config_clock_in,
	input  wire logic                  fabric_clock_source_in,
	input  wire logic                  tck_in,
	input  wire logic                  load_complete_in,
	input  wire logic                  crc_error_in,
	input  wire logic [2:0]            mode_select_in,
	input  wire logic [1:0]            startup_clock_select_in,
	input  wire logic [1:0]            oscillator_rate_select_in,
	input  wire logic [2:0]            done_phase_in,
	input  wire logic [2:0]            tristate_release_phase_in,
	input  wire logic [2:0]            write_enable_phase_in,
	input  wire logic [2:0]            lock_wait_phase_in,
	input  wire logic [LOCK_WIDTH-1:0] lock_wait_mask_in,
	input  wire logic [LOCK_WIDTH-1:0] clock_manager_locked_in,
	input  wire logic                  fabric_set_reset_in,
	input  wire logic                  fabric_tristate_in,
	input  wire logic                  capture_request_in,
	input  wire logic                  readback_request_in,
	input  wire logic [31:0]           chain_bit_count_in,
	output logic                       global_set_reset_out,
	output logic                       global_output_tristate_out,
	output logic                       global_write_enable_sig_out,
	output logic [1:0]                 oscillator_rate_select_out,
	output logic                       capture_strobe_out,
	output logic                       readback_enable_out,
	output logic                       chain_length_error_out,
	output logic [2:0]                 startup_phase_out,
	output logic                       configured_out
);
	// ********************************************************
	// Input synchronisers
	// ********************************************************
	edge_sync_if prog_s ();
	edge_sync_if init_s ();
	edge_sync_if done_s ();
	edge_sync_if cclk_s ();
	edge_sync_if uclk_s ();
	edge_sync_if tck_s ();

	pin_sync #(.RESET_VAL(1'b1)) u_prog (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(program_request_n_in), .sync(prog_s));
	pin_sync #(.RESET_VAL(1'b0)) u_init (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(init_status_n_in), .sync(init_s));
	pin_sync #(.RESET_VAL(1'b0)) u_done (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(config_done_in), .sync(done_s));
	pin_sync #(.RESET_VAL(1'b0)) u_cclk (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(config_clock_in), .sync(cclk_s));
	pin_sync #(.RESET_VAL(1'b0)) u_uclk (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(fabric_clock_source_in), .sync(uclk_s));
	pin_sync #(.RESET_VAL(1'b0)) u_tck (.clk_in(clk_in), .rst_in(rst_in),
		.pin_in(tck_in), .sync(tck_s));

	logic [LOCK_WIDTH-1:0] lock_meta;
	logic [LOCK_WIDTH-1:0] lock_sync;
	logic                  crc_meta;
	logic                  crc_sync;
	logic                  load_meta;
	logic                  load_sync;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			lock_meta <= '0;
			lock_sync <= '0;
			crc_meta  <= 1'b0;
			crc_sync  <= 1'b0;
			load_meta <= 1'b0;
			load_sync <= 1'b0;
		end else begin
			lock_meta <= clock_manager_locked_in;
			lock_sync <= lock_meta;
			crc_meta  <= crc_error_in;
			crc_sync  <= crc_meta;
			load_meta <= load_complete_in;
			load_sync <= load_meta;
		end
	end

	// ********************************************************
	// Decode
	// ********************************************************
	cfg_state_t state;
	cfg_state_t next_state;
	logic [2:0] phase;
	logic [2:0] next_phase;
	localparam int CNT_W = $clog2(CLEAR_CYCLES + 1);
	logic [CNT_W-1:0] clear_cnt;
	logic       prog_low_seen;
	logic       tri_released;
	logic       we_released;
	logic       done_released;
	logic       gsr_pulse;
	logic       crc_fault;
	logic [1:0] rate;

	wire start_tick = (startup_clock_select_in == clk_sel_fabric) ? uclk_s.rise :
		(startup_clock_select_in == clk_sel_test) ? tck_s.rise : cclk_s.rise;
	wire locks_ok    = &(lock_sync | ~lock_wait_mask_in);
	wire lock_stall  = (lock_wait_phase_in != phase_no_wait) &&
		(phase == lock_wait_phase_in) && !locks_ok;
	wire tri_hit     = (tristate_release_phase_in == phase_done_wait) ? done_s.level :
		(phase >= tristate_release_phase_in);
	wire we_hit      = (write_enable_phase_in == phase_done_wait) ? done_s.level :
		(phase >= write_enable_phase_in);
	wire done_hit    = (phase >= done_phase_in);
	wire clear_end   = (clear_cnt == CNT_W'(CLEAR_CYCLES));
	wire program_rel = prog_low_seen && prog_s.level;
	wire in_user     = (state == st_user);
	wire rb_mode     = (mode_select_in == mode_slave_par) || (mode_select_in == mode_test);

	// ********************************************************
	// Sequencer
	// ********************************************************
	always_comb begin
		next_state = state;
		next_phase = phase;
		case (state)
			st_clear: begin
				if (clear_end) begin
					next_state = st_init_wait;
				end
			end
			st_init_wait: begin
				if (init_s.level) begin
					next_state = st_load;
				end
			end
			st_load: begin
				if (load_sync && !crc_fault) begin
					next_state = st_startup;
					next_phase = '0;
				end
			end
			st_startup: begin
				if (start_tick && !lock_stall) begin
					if (phase == last_phase) begin
						if (tri_released && we_released) begin
							next_state = st_user;
						end
					end else begin
						next_phase = phase + 3'h1;
					end
				end
			end
			st_user: begin
				next_state = st_user;
			end
			default: begin
				next_state = st_clear;
			end
		endcase
		if (!prog_s.level) begin
			next_state = st_clear;
			next_phase = '0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= st_clear;
			phase <= '0;
		end else begin
			state <= next_state;
			phase <= next_phase;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || state != st_clear || !prog_s.level) begin
			clear_cnt <= '0;
		end else if (!clear_end) begin
			clear_cnt <= clear_cnt + 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || program_rel) begin
			prog_low_seen <= 1'b0;
		end else if (!prog_s.level) begin
			prog_low_seen <= 1'b1;
		end
	end

	// ********************************************************
	// Start-up releases
	// ********************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in || !prog_s.level || state == st_clear) begin
			done_released <= 1'b0;
			tri_released  <= 1'b0;
			we_released   <= 1'b0;
			gsr_pulse     <= 1'b0;
		end else if (state == st_startup && start_tick && !lock_stall) begin
			done_released <= done_released | done_hit;
			tri_released  <= tri_released | tri_hit;
			we_released   <= we_released | (tri_released & we_hit);
			gsr_pulse     <= (phase == '0);
		end else begin
			gsr_pulse     <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || state == st_clear) begin
			crc_fault <= 1'b0;
		end else if (crc_sync && state == st_load) begin
			crc_fault <= 1'b1;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in || state == st_clear) begin
			rate <= rate_3mhz;
		end else if (state == st_load && load_sync) begin
			rate <= oscillator_rate_select_in;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			capture_strobe_out     <= 1'b0;
			chain_length_error_out <= 1'b0;
		end else begin
			capture_strobe_out     <= in_user && capture_request_in;
			chain_length_error_out <= (mode_select_in == mode_slave_serial) &&
				(chain_bit_count_in > max_chain_bits);
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	wire init_low = (state == st_clear) || crc_fault;
	assign init_status_n_out           = 1'b0;
	assign init_status_n_oe_n_out      = ~init_low;
	assign config_done_out             = 1'b0;
	assign config_done_oe_n_out        = done_released;
	assign global_set_reset_out        = !tri_released || gsr_pulse ||
		(we_released && fabric_set_reset_in);
	assign global_output_tristate_out  = !tri_released ||
		(we_released && fabric_tristate_in);
	assign global_write_enable_sig_out = we_released;
	assign oscillator_rate_select_out  = rate;
	assign readback_enable_out         = in_user && rb_mode && readback_request_in;
	assign startup_phase_out           = phase;
	assign configured_out              = in_user;
endmodule
`default_nettype wire

//--- hw/edge_sync_if.sv
// Carrier between the sequencer and its synchroniser instances.
// Assumes both ends share clk_in.
`timescale 1ns/1ps
`default_nettype none
interface edge_sync_if;
	logic level;
	logic rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface
`default_nettype wire

//--- hw/pin_sync.sv
// Two-flop synchroniser with rising-edge detect on the synchronised level.
// Assumes clk_in is the sampling clock and rst_in is synchronous.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter logic RESET_VAL = 1'b0
) (
	input  wire logic clk_in,
	input  wire logic rst_in,
	input  wire logic pin_in,
	edge_sync_if.src  sync
);
	logic meta;
	logic stable;
	logic prev;

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			meta   <= RESET_VAL;
			stable <= RESET_VAL;
			prev   <= RESET_VAL;
		end else begin
			meta   <= pin_in;
			stable <= meta;
			prev   <= stable;
		end
	end

	assign sync.level = stable;
	assign sync.rise  = stable & ~prev;
endmodule
`default_nettype wire
